//--- logic/rmos_consts.svh
// constants for the remap output-select block: register index map, field layout, reset values
// assumes it is included by the package and the design modules of this block only
// Summary of operation
// - bits 13 to 8 of an output-select register choose the peripheral function driving its upper virtual port.
// - bits 5 to 0 of an output-select register choose the peripheral function driving its lower virtual port.
// - bits 15 to 14 and 7 to 6 of an output-select register ignore writes and read back as zero.
// - both selectors load zero at power-on reset and software may read and write them.
// - the two ports of the top output-select register are internal virtual ports, not package pins; the code also drives them on remap_port_out.
// - every output-select register has the same two 6-bit selectors with all other bits reading zero.
`ifndef RMOS_CONSTS_SVH
`define RMOS_CONSTS_SVH

// apb word index map, byte address is four times the index
`define RMOS_ADDR_W 12
`define RMOS_WIDX_W 10
`define RMOS_OSEL_WBASE 10'h000
`define RMOS_LOCK_WIDX 10'h020
`define RMOS_VSTAT_WIDX 10'h021
`define RMOS_IN_WBASE 10'h040

// output-select field layout
`define RMOS_SEL_W 6
`define RMOS_HI_MSB 13
`define RMOS_HI_LSB 8
`define RMOS_LO_MSB 5
`define RMOS_LO_LSB 0
`define RMOS_OSEL_UNIMPL 32'hffff_c0c0
`define RMOS_SEL_RST 6'h00
`define RMOS_NO_FUNC 6'h00

// lock control and input-route storage
`define RMOS_LOCK_BIT 11
`define RMOS_REG_W 16
`define RMOS_IN_RST 16'h0000

`endif

//--- logic/rmos_pkg.sv
// types shared by the remap output-select block
// assumes the constants header sits beside it
package rmos_pkg;
`include "rmos_consts.svh"

   // apb access sequencing of the register slave
   typedef enum {RMOS_IDLE, RMOS_DONE} rmos_phase_e;

   // selector pair of one output-select register
   typedef struct packed {
      logic [`RMOS_SEL_W-1:0] hi;
      logic [`RMOS_SEL_W-1:0] lo;
   } rmos_sel_pair_s;

   // apb request as seen by the slave
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [`RMOS_ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } rmos_apb_req_s;
endpackage

//--- logic/rmos_func_mux.sv
// one remappable port: picks a peripheral output by function number
// assumes peripheral outputs come from logic on the same clock
`timescale 1ns/100ps
`include "rmos_consts.svh"
module rmos_func_mux
   import rmos_pkg::*;
#(
   parameter int NUM_FUNCS = 64
) (
   input wire logic [NUM_FUNCS-1:0] periph_out,
   input wire logic [`RMOS_SEL_W-1:0] func_sel,
   output logic port_out
);

   // zero and numbers past the supported range leave the port low
   always_comb begin
      port_out = 1'b0;
      if (func_sel != `RMOS_NO_FUNC && int'(func_sel) < NUM_FUNCS) begin
         port_out = periph_out[func_sel];
      end
   end
endmodule

//--- logic/rmos_route_mem.sv
// storage for the input-route registers, registered read port
// assumes one read or one write per cycle from the apb slave
`timescale 1ns/100ps
`include "rmos_consts.svh"
module rmos_route_mem
   import rmos_pkg::*;
#(
   parameter int DEPTH = 36,
   parameter int AW = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [`RMOS_REG_W-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [`RMOS_REG_W-1:0] rd_data
);

   typedef struct packed {
      logic [DEPTH-1:0][`RMOS_REG_W-1:0] mem;
      logic [`RMOS_REG_W-1:0] rdata;
   } rmos_mem_state_s;

   rmos_mem_state_s st_q;
   rmos_mem_state_s st_d;

   // out-of-range addresses are filtered by the slave decode
   always_comb begin
      st_d = st_q;
      if (wr_en) begin
         st_d.mem[wr_addr] = wr_data;
      end
      if (rd_en) begin
         st_d.rdata = st_q.mem[rd_addr];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rd_data = st_q.rdata;
endmodule

//--- logic/rmos_output_select.sv
// remap output-select unit: apb register slave, output-select bank and port muxes
// assumes apb3 signalling from a master on pclk and peripheral outputs on the same clock
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "rmos_consts.svh"
module rmos_output_select
   import rmos_pkg::*;
#(
   parameter int OSEL_REGS = 20,
   parameter int IN_REGS = 36,
   parameter int NUM_FUNCS = 64
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`RMOS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NUM_FUNCS-1:0] periph_out,
   output logic [2*OSEL_REGS-1:0] remap_port_out,
   output logic virtual_port_hi,
   output logic virtual_port_lo,
   output logic remap_config_lock
);

   localparam int OW = (OSEL_REGS > 1) ? $clog2(OSEL_REGS) : 1;
   localparam int IW = (IN_REGS > 1) ? $clog2(IN_REGS) : 1;

   typedef struct packed {
      rmos_sel_pair_s [OSEL_REGS-1:0] sel;
      logic lock;
      rmos_phase_e phase;
      logic [31:0] rdata;
      logic err;
      logic mem_rd;
      logic settled;
   } rmos_top_state_s;

   rmos_top_state_s st_q;
   rmos_top_state_s st_d;

   logic [`RMOS_WIDX_W-1:0] widx;
   logic [`RMOS_WIDX_W-1:0] osel_off;
   logic [`RMOS_WIDX_W-1:0] in_off;
   logic osel_hit;
   logic in_hit;
   logic lock_hit;
   logic vstat_hit;
   logic any_hit;
   logic access;
   logic mem_wr;
   logic mem_rd;
   logic [`RMOS_REG_W-1:0] mem_rdata;
   logic [OW-1:0] osel_idx;
   logic [IW-1:0] in_idx;

   // word decode, every register takes one aligned 32-bit word
   assign widx = paddr[`RMOS_ADDR_W-1:2];
   assign osel_off = widx - `RMOS_OSEL_WBASE;
   assign in_off = widx - `RMOS_IN_WBASE;
   assign osel_hit = (widx >= `RMOS_OSEL_WBASE) && (osel_off < `RMOS_WIDX_W'(OSEL_REGS));
   assign in_hit = (widx >= `RMOS_IN_WBASE) && (in_off < `RMOS_WIDX_W'(IN_REGS));
   assign lock_hit = (widx == `RMOS_LOCK_WIDX);
   assign vstat_hit = (widx == `RMOS_VSTAT_WIDX);
   assign any_hit = osel_hit || in_hit || lock_hit || vstat_hit;
   assign osel_idx = osel_off[OW-1:0];
   assign in_idx = in_off[IW-1:0];
   assign access = psel && penable;

   // input-route storage reads in the first access cycle, writes on the completing one
   assign mem_rd = access && (st_q.phase == RMOS_IDLE) && !pwrite && in_hit;
   assign mem_wr = access && (st_q.phase == RMOS_DONE) && pwrite && in_hit;

   rmos_route_mem #(
      .DEPTH(IN_REGS),
      .AW(IW)
   ) u_route_mem (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(mem_wr),
      .wr_addr(in_idx),
      .wr_data(pwdata[`RMOS_REG_W-1:0]),
      .rd_en(mem_rd),
      .rd_addr(in_idx),
      .rd_data(mem_rdata)
   );

   // slave sequencing: every access holds one wait cycle so read data come from flops
   always_comb begin
      st_d = st_q;
      st_d.settled = 1'b1;
      case (st_q.phase)
         RMOS_IDLE: begin
            if (access) begin
               st_d.phase = RMOS_DONE;
               st_d.err = !any_hit;
               st_d.mem_rd = in_hit && !pwrite;
               st_d.rdata = '0;
               if (!pwrite && osel_hit) begin
                  // unimplemented bits come back as zero
                  st_d.rdata = 32'({2'b00, st_q.sel[osel_idx].hi, 2'b00, st_q.sel[osel_idx].lo});
               end else if (!pwrite && lock_hit) begin
                  st_d.rdata = 32'(st_q.lock) << `RMOS_LOCK_BIT;
               end else if (!pwrite && vstat_hit) begin
                  st_d.rdata = 32'({virtual_port_hi, virtual_port_lo});
               end
            end
         end
         RMOS_DONE: begin
            st_d.phase = RMOS_IDLE;
            // a write takes effect only on the edge that completes the transfer
            if (pwrite && osel_hit) begin
               st_d.sel[osel_idx].hi = pwdata[`RMOS_HI_MSB:`RMOS_HI_LSB];
               st_d.sel[osel_idx].lo = pwdata[`RMOS_LO_MSB:`RMOS_LO_LSB];
            end
            if (pwrite && lock_hit) begin
               st_d.lock = pwdata[`RMOS_LOCK_BIT];
            end
         end
         default: begin
            st_d.phase = RMOS_IDLE;
         end
      endcase
   end

   // selectors come up at zero so no peripheral drives a port after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // answer: pready on the second access cycle, error only for unmapped words
   assign pready = (st_q.phase == RMOS_DONE);
   assign pslverr = (st_q.phase == RMOS_DONE) && st_q.err;
   assign prdata = st_q.mem_rd ? 32'(mem_rdata) : st_q.rdata;
   assign remap_config_lock = st_q.lock;

   // one mux per port; routing is combinational so peripheral timing is kept
   genvar gi;
   generate
      for (gi = 0; gi < 2 * OSEL_REGS; gi++) begin : g_port
         logic [`RMOS_SEL_W-1:0] port_sel;
         // odd ports take the upper selector, even ports the lower one
         assign port_sel = (gi % 2 == 1) ? st_q.sel[gi / 2].hi : st_q.sel[gi / 2].lo;
         rmos_func_mux #(
            .NUM_FUNCS(NUM_FUNCS)
         ) u_mux (
            .periph_out(periph_out),
            .func_sel(port_sel),
            .port_out(remap_port_out[gi])
         );
         // every register's ports obey the same layout, so each one is watched, not only the top pair
         property p_port_follow;
            @(posedge pclk) disable iff (!presetn)
               (port_sel != `RMOS_NO_FUNC) && (int'(port_sel) < NUM_FUNCS) |->
                  remap_port_out[gi] == periph_out[port_sel];
         endproperty
         a_port_follow: assert property (p_port_follow)
            else $error("remappable port not following its selector");
         property p_port_quiet;
            @(posedge pclk) disable iff (!presetn)
               (port_sel == `RMOS_NO_FUNC) |-> !remap_port_out[gi];
         endproperty
         a_port_quiet: assert property (p_port_quiet)
            else $error("remappable port driven with selector zero");
      end
   endgenerate

   // the top register's pair feeds the virtual port outputs and also the top two bits of remap_port_out
   assign virtual_port_hi = remap_port_out[2 * OSEL_REGS - 1];
   assign virtual_port_lo = remap_port_out[2 * OSEL_REGS - 2];

   // checks on the register slave and the routing
   sequence s_osel_wr;
      psel && penable && pready && pwrite && osel_hit;
   endsequence

   sequence s_osel_rd;
      psel && penable && pready && !pwrite && osel_hit;
   endsequence

   sequence s_wait_cycle;
      psel && penable && !pready;
   endsequence

   sequence s_idle_then_setup;
      !psel ##1 psel && !penable;
   endsequence

   property p_hi_sel_load;
      @(posedge pclk) disable iff (!presetn)
         s_osel_wr |=> st_q.sel[$past(osel_idx)].hi == $past(pwdata[`RMOS_HI_MSB:`RMOS_HI_LSB]);
   endproperty
   a_hi_sel_load: assert property (p_hi_sel_load)
      else $error("upper selector did not take written bits");

   property p_lo_sel_load;
      @(posedge pclk) disable iff (!presetn)
         s_osel_wr |=> st_q.sel[$past(osel_idx)].lo == $past(pwdata[`RMOS_LO_MSB:`RMOS_LO_LSB]);
   endproperty
   a_lo_sel_load: assert property (p_lo_sel_load)
      else $error("lower selector did not take written bits");

   property p_unimpl_zero;
      @(posedge pclk) disable iff (!presetn)
         s_osel_rd |-> (prdata & `RMOS_OSEL_UNIMPL) == 32'h0000_0000;
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero)
      else $error("unimplemented output-select bits read nonzero");

   property p_reset_zero;
      @(posedge pclk) disable iff (!presetn)
         !st_q.settled |-> (st_q.sel == '0) && !virtual_port_hi && !virtual_port_lo;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("selectors not zero after reset");

   property p_virtual_pair;
      @(posedge pclk) disable iff (!presetn)
         $stable(st_q.sel[OSEL_REGS-1]) && $stable(periph_out) |->
            $stable(virtual_port_hi) && $stable(virtual_port_lo);
   endproperty
   a_virtual_pair: assert property (p_virtual_pair)
      else $error("virtual port changed without a cause");

   property p_zero_sel_idle;
      @(posedge pclk) disable iff (!presetn)
         (st_q.sel[OSEL_REGS-1].hi == `RMOS_NO_FUNC) |-> !virtual_port_hi ##1
            ((st_q.sel[OSEL_REGS-1].hi != `RMOS_NO_FUNC) || !virtual_port_hi);
   endproperty
   a_zero_sel_idle: assert property (p_zero_sel_idle)
      else $error("port driven with selector zero");

   property p_routed;
      @(posedge pclk) disable iff (!presetn)
         (st_q.sel[OSEL_REGS-1].lo != `RMOS_NO_FUNC) && (int'(st_q.sel[OSEL_REGS-1].lo) < NUM_FUNCS) |->
            virtual_port_lo == periph_out[st_q.sel[OSEL_REGS-1].lo];
   endproperty
   a_routed: assert property (p_routed)
      else $error("lower virtual port not following selected function");

   property p_layout_read;
      @(posedge pclk) disable iff (!presetn)
         s_osel_wr ##1 s_idle_then_setup ##1 s_wait_cycle ##1 s_osel_rd ##0 (paddr == $past(paddr, 4)) |->
            prdata[`RMOS_HI_MSB:`RMOS_HI_LSB] == $past(pwdata[`RMOS_HI_MSB:`RMOS_HI_LSB], 4) &&
            prdata[`RMOS_LO_MSB:`RMOS_LO_LSB] == $past(pwdata[`RMOS_LO_MSB:`RMOS_LO_LSB], 4);
   endproperty
   a_layout_read: assert property (p_layout_read)
      else $error("output-select readback does not match layout");

   property p_one_wait;
      @(posedge pclk) disable iff (!presetn)
         s_wait_cycle |=> pready && (pslverr == !$past(any_hit));
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("apb answer not on second access cycle");

   // the upper port of the top pair, checked apart from the lower one so a swapped pair shows
   property p_hi_routed;
      @(posedge pclk) disable iff (!presetn)
         (st_q.sel[OSEL_REGS-1].hi != `RMOS_NO_FUNC) && (int'(st_q.sel[OSEL_REGS-1].hi) < NUM_FUNCS) |->
            virtual_port_hi == periph_out[st_q.sel[OSEL_REGS-1].hi];
   endproperty
   a_hi_routed: assert property (p_hi_routed)
      else $error("upper virtual port not following selected function");

   property p_lo_quiet;
      @(posedge pclk) disable iff (!presetn)
         (st_q.sel[OSEL_REGS-1].lo == `RMOS_NO_FUNC) |-> !virtual_port_lo;
   endproperty
   a_lo_quiet: assert property (p_lo_quiet)
      else $error("lower virtual port driven with selector zero");

   // only a completed software write may move a selector
   property p_sel_hold;
      @(posedge pclk) disable iff (!presetn)
         !(psel && penable && pready && pwrite && osel_hit) |=> $stable(st_q.sel);
   endproperty
   a_sel_hold: assert property (p_sel_hold)
      else $error("selector changed without a completed write");

   property p_osel_no_err;
      @(posedge pclk) disable iff (!presetn)
         psel && penable && pready && osel_hit |-> !pslverr;
   endproperty
   a_osel_no_err: assert property (p_osel_no_err)
      else $error("output-select access answered with an error");

   // lock bit is stored only; it must still follow the bus exactly
   property p_lock_load;
      @(posedge pclk) disable iff (!presetn)
         psel && penable && pready && pwrite && lock_hit |=> remap_config_lock == $past(pwdata[`RMOS_LOCK_BIT]);
   endproperty
   a_lock_load: assert property (p_lock_load)
      else $error("lock bit did not take written value");

   property p_lock_hold;
      @(posedge pclk) disable iff (!presetn)
         !(psel && penable && pready && pwrite && lock_hit) |=> $stable(remap_config_lock);
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("lock bit changed without a write");

   property p_lock_read;
      @(posedge pclk) disable iff (!presetn)
         psel && penable && pready && !pwrite && lock_hit |-> prdata == (32'(remap_config_lock) << `RMOS_LOCK_BIT);
   endproperty
   a_lock_read: assert property (p_lock_read)
      else $error("lock word read back wrong");

   // status word is captured on the wait-cycle edge, so it shows the ports of that cycle
   property p_vstat_read;
      @(posedge pclk) disable iff (!presetn)
         s_wait_cycle ##1 (psel && penable && pready && !pwrite && vstat_hit) |->
            prdata == 32'({$past(virtual_port_hi), $past(virtual_port_lo)});
   endproperty
   a_vstat_read: assert property (p_vstat_read)
      else $error("virtual port status read back wrong");

   property p_route_upper;
      @(posedge pclk) disable iff (!presetn)
         psel && penable && pready && !pwrite && in_hit |-> prdata[31:`RMOS_REG_W] == 16'h0000;
   endproperty
   a_route_upper: assert property (p_route_upper)
      else $error("input-route upper half read nonzero");

   property p_err_read_zero;
      @(posedge pclk) disable iff (!presetn)
         psel && penable && pready && !pwrite && pslverr |-> prdata == 32'h0000_0000;
   endproperty
   a_err_read_zero: assert property (p_err_read_zero)
      else $error("unmapped read returned data");

   // answer lasts one cycle and never appears outside a transfer
   property p_ready_pulse;
      @(posedge pclk) disable iff (!presetn)
         pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("pready held longer than one cycle");

   property p_idle_quiet;
      @(posedge pclk) disable iff (!presetn)
         !psel |-> !pready && !pslverr;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("apb answer without a selected transfer");
endmodule

//--- tb/rmos_periph_model.sv
// partner model: the peripheral output functions that feed the remap muxes
// assumes pclk and presetn of the block; run low freezes the pattern
`timescale 1ns/100ps
module rmos_periph_model
   import rmos_pkg::*;
#(
   parameter logic [63:0] PATTERN = 64'h9c3a_5e0f_71b4_26d8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   output logic [63:0] periph_out
);
   logic [63:0] pat_q;
   // flips every cycle while running, so a stale or wrong route cannot hide
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pat_q <= PATTERN;
      end else if (run) begin
         pat_q <= ~pat_q;
      end
   end
   // function 0 is unused; held high so a leaking zero selector shows up
   assign periph_out = {pat_q[63:1], 1'b1};
endmodule

//--- tb/rmos_output_select_test.sv
// self-checking bench for the remap output-select unit
// assumes default parameters: 20 output-select regs, 36 input-route regs, 64 functions
`timescale 1ns/100ps
module rmos_output_select_test
   import rmos_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic run = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, virtual_port_hi, virtual_port_lo, remap_config_lock;
   logic [63:0] periph_out;
   logic [39:0] remap_port_out;
   int errors = 0;
   int checks = 0;

   always #25 pclk = ~pclk;

   rmos_periph_model model (.pclk(pclk), .presetn(presetn), .run(run), .periph_out(periph_out));
   rmos_output_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .periph_out(periph_out), .remap_port_out(remap_port_out),
      .virtual_port_hi(virtual_port_hi), .virtual_port_lo(virtual_port_lo),
      .remap_config_lock(remap_config_lock));

   task automatic test_done();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one apb transfer; access held until pready is seen high at a rising edge, data taken there
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         errors++;
         $display("[ERR] pready expected 1 seen %b", pready);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk("prdata", exp, r);
      chk("pslverr", {31'h0, exp_err}, {31'h0, e});
   endtask

   function automatic logic pexp(input logic [5:0] s);
      return (s == 6'h00) ? 1'b0 : periph_out[s];
   endfunction

   // two cycles, because the pattern flips each cycle
   task automatic chk_port(input int i, input logic [5:0] hi, input logic [5:0] lo);
      repeat (2) begin
         @(negedge pclk);
         chk("remap_port_out", {30'h0, pexp(hi), pexp(lo)}, {30'h0, remap_port_out[2*i+1 -: 2]});
         if (i == 19) begin
            chk("virtual_port", {30'h0, pexp(hi), pexp(lo)}, {30'h0, virtual_port_hi, virtual_port_lo});
         end
      end
   endtask

   task automatic t_reset();
      rd(12'h04c, 32'h0, 1'b0);
      rd(12'h080, 32'h0, 1'b0);
      rd(12'h18c, 32'h0, 1'b0);
      chk_port(19, 6'h00, 6'h00);
   endtask

   task automatic t_top();
      logic [5:0] his [4] = '{6'h3f, 6'h00, 6'h15, 6'h01};
      logic [5:0] los [4] = '{6'h01, 6'h2a, 6'h00, 6'h3e};
      for (int k = 0; k < 4; k++) begin
         wr(12'h04c, {16'hffff, 2'b11, his[k], 2'b11, los[k]});
         rd(12'h04c, {18'h0, his[k], 2'b00, los[k]}, 1'b0);
         chk_port(19, his[k], los[k]);
      end
   endtask

   // distinct values everywhere, checked after all writes so aliasing shows
   task automatic t_all();
      for (int i = 0; i < 20; i++) begin
         wr(12'(4 * i), {16'h0, 2'b11, 6'(i + 1), 2'b11, 6'(63 - i)});
      end
      for (int i = 0; i < 20; i++) begin
         rd(12'(4 * i), {18'h0, 6'(i + 1), 2'b00, 6'(63 - i)}, 1'b0);
         chk_port(i, 6'(i + 1), 6'(63 - i));
      end
   endtask

   task automatic t_misc();
      @(posedge pclk);
      run <= 1'b0;
      @(negedge pclk);
      rd(12'h084, {30'h0, pexp(6'd20), pexp(6'd44)}, 1'b0);
      run <= 1'b1;
      wr(12'h080, 32'h0000_0800);
      rd(12'h080, 32'h0000_0800, 1'b0);
      chk("remap_config_lock", 32'h1, {31'h0, remap_config_lock});
      wr(12'h18c, 32'hdead_beef);
      rd(12'h18c, 32'h0000_beef, 1'b0);
      wr(12'h050, 32'h0000_3f3f);
      rd(12'h050, 32'h0, 1'b1);
      rd(12'h04c, {18'h0, 6'd20, 2'b00, 6'd44}, 1'b0);
   endtask

   // reset again in mid-run: the selectors of registers 19 and 0 must fall back to zero
   task automatic t_rst2();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h04c, 32'h0, 1'b0);
      rd(12'h000, 32'h0, 1'b0);
      chk_port(19, 6'h00, 6'h00);
   endtask

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_top();
      t_all();
      t_misc();
      t_rst2();
      test_done();
   end

   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #(50 * 5000);
      errors++;
      $display("[ERR] run_end expected finished seen timeout");
      test_done();
   end
endmodule
